//--- rtl/pps_pkg.sv
// Function
// - per-pin direction; ports 8,8,8,2,8 bits
// - software pull-up on input pins
// - every pin is input after reset
// - three interrupt inputs, selectable valid edge
// - port four pins detect key return
// - port two pins 0-3 carry serial
// - timer, buzzer and capture pins shared
// - decode 64 Kbyte space, 16-bit address
package pps_pkg;

    localparam int NPINS  = 34;
    localparam int NPORTS = 5;
    localparam int AW     = 16;

    // byte addresses
    localparam logic [AW-1:0] OFS_DATA   = 16'h0000;
    localparam logic [AW-1:0] OFS_DIR    = 16'h0020;
    localparam logic [AW-1:0] OFS_PULL   = 16'h0040;
    localparam logic [AW-1:0] OFS_ALT    = 16'h0060;
    localparam logic [AW-1:0] OFS_EDGE   = 16'h0064;
    localparam logic [AW-1:0] OFS_STATUS = 16'h0068;
    localparam logic [AW-1:0] OFS_END    = 16'h006C;

    // flat pin positions
    localparam int PIN_SCK   = 16;
    localparam int PIN_SOUT  = 17;
    localparam int PIN_SIN   = 18;
    localparam int PIN_SSN   = 19;
    localparam int PIN_IRQ_A = 20;
    localparam int PIN_IRQ_B = 21;
    localparam int PIN_IRQ_C = 22;
    localparam int PIN_TMR8  = 23;
    localparam int PIN_TMR16 = 24;
    localparam int PIN_BUZZ  = 25;
    localparam int PIN_KEY0  = 26;

    // alternate output enable bits
    localparam int ALT_SCK   = 0;
    localparam int ALT_SOUT  = 1;
    localparam int ALT_TXD   = 2;
    localparam int ALT_TMR8  = 3;
    localparam int ALT_TMR16 = 4;
    localparam int ALT_BUZZ  = 5;

    // edge select field, two bits per interrupt input
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    localparam logic [7:0]       RST_BYTE = 8'h00;
    localparam logic [NPINS-1:0] RST_OE_N = {NPINS{1'b1}};
    localparam logic [NPINS-1:0] RST_PINS = {NPINS{1'b0}};

    typedef logic [NPORTS-1:0][7:0] pps_ports_t;

    typedef struct packed {
        logic sync_serial_clk;
        logic sync_serial_dout;
        logic async_transmit_out;
        logic small_timer_out;
        logic wide_timer_out;
        logic buzzer_out;
    } pps_alt_out_t;

    typedef struct packed {
        logic sync_serial_clk;
        logic async_serial_clk_in;
        logic sync_serial_din;
        logic async_receive_in;
        logic serial_chip_select_n;
        logic ext_irq_in_a;
        logic ext_irq_in_b;
        logic ext_irq_in_c;
        logic capture_edge_in;
        logic small_timer_count_in;
    } pps_alt_in_t;

    function automatic logic [NPINS-1:0] pps_flat(input pps_ports_t v);
        return {v[4], v[3][1:0], v[2], v[1], v[0]};
    endfunction : pps_flat

    function automatic logic [7:0] pps_port(input logic [NPINS-1:0] v, input logic [2:0] n);
        logic [7:0] r;
        r = 8'h00;
        unique case (n)
            3'h0: r = v[7:0];
            3'h1: r = v[15:8];
            3'h2: r = v[23:16];
            3'h3: r = {6'h00, v[25:24]};
            3'h4: r = v[33:26];
            default: r = 8'h00;
        endcase
        return r;
    endfunction : pps_port

endpackage : pps_pkg

//--- rtl/pps_port_pins.sv
`timescale 1ns/1ps
module pps_port_pins
    import pps_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [AW-1:0]      paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [NPINS-1:0]   pin_in,
    output logic      [NPINS-1:0]   pin_out,
    output logic      [NPINS-1:0]   pin_oe_n,
    output logic      [NPINS-1:0]   pull_en,
    input  wire pps_alt_out_t       alt_out,
    output pps_alt_in_t             alt_in,
    output logic      [NPINS-1:0]   pin_level,
    output logic      [2:0]         ext_irq_req,
    output logic                    key_return_req
);

    pps_ports_t         latch_r, dir_r, pu_r;
    logic [5:0]         alt_r;
    logic [5:0]         edge_cfg_r;
    logic [2:0]         irq_flag_r;
    logic [7:0]         kr_flag_r;
    logic [NPINS-1:0]   pin_s1, pin_s2, pin_s3;
    logic [NPINS-1:0]   pin_out_r, pin_oe_n_r, pull_en_r;
    logic [31:0]        prdata_r;
    logic               pready_r, pslverr_r;
    pps_alt_in_t        alt_in_r;
    logic [2:0]         irq_req_r;
    logic               kr_req_r;

    // bus decode, full 16-bit space; anything outside the map errors
    wire       setup   = psel && !penable;
    wire [2:0] grp     = paddr[7:5];
    wire [2:0] idx     = paddr[4:2];
    wire       in_map  = (paddr[15:8] == 8'h00) && (paddr[1:0] == 2'h0) && (paddr < OFS_END)
                         && ((grp < 3'h3 && idx < 3'h5) || grp == 3'h3);
    wire       wr_en   = ce && psel && penable && pready_r && pwrite && !pslverr_r;
    wire       wr_data = wr_en && grp == 3'h0;
    wire       wr_dir  = wr_en && grp == 3'h1;
    wire       wr_pull = wr_en && grp == 3'h2;
    wire       wr_alt  = wr_en && paddr == OFS_ALT;
    wire       wr_edge = wr_en && paddr == OFS_EDGE;
    wire       wr_stat = wr_en && paddr == OFS_STATUS;

    // port 3 keeps only two bits; upper bits read zero
    wire [7:0] wmask   = (idx == 3'h3) ? 8'h03 : 8'hFF;

    wire [NPINS-1:0] dir_all = pps_flat(dir_r);
    wire [NPINS-1:0] pu_all  = pps_flat(pu_r);
    wire [NPINS-1:0] lat_all = pps_flat(latch_r);
    // reads show the latch for outputs and the pin for inputs
    wire [NPINS-1:0] rd_all  = (dir_all & lat_all) | (~dir_all & pin_s2);

    wire [7:0] rd_port = (grp == 3'h0) ? pps_port(rd_all, idx) :
                         (grp == 3'h1) ? pps_port(dir_all, idx) : pps_port(pu_all, idx);
    wire [31:0] rd_misc = (paddr == OFS_ALT)  ? {26'h0, alt_r} :
                          (paddr == OFS_EDGE) ? {26'h0, edge_cfg_r} :
                          {16'h0, kr_flag_r, 5'h00, irq_flag_r};
    wire [31:0] rd_word = (grp == 3'h3) ? rd_misc : {24'h0, rd_port};

    // alternate outputs override the latch on their pin
    wire [NPINS-1:0] alt_mask = ({{(NPINS-1){1'b0}}, alt_r[ALT_SCK]} << PIN_SCK)
                              | ({{(NPINS-1){1'b0}}, alt_r[ALT_SOUT] | alt_r[ALT_TXD]} << PIN_SOUT)
                              | ({{(NPINS-1){1'b0}}, alt_r[ALT_TMR8]} << PIN_TMR8)
                              | ({{(NPINS-1){1'b0}}, alt_r[ALT_TMR16]} << PIN_TMR16)
                              | ({{(NPINS-1){1'b0}}, alt_r[ALT_BUZZ]} << PIN_BUZZ);
    wire sout_val = alt_r[ALT_TXD] ? alt_out.async_transmit_out : alt_out.sync_serial_dout;
    wire [NPINS-1:0] alt_val  = ({{(NPINS-1){1'b0}}, alt_out.sync_serial_clk} << PIN_SCK)
                              | ({{(NPINS-1){1'b0}}, sout_val} << PIN_SOUT)
                              | ({{(NPINS-1){1'b0}}, alt_out.small_timer_out} << PIN_TMR8)
                              | ({{(NPINS-1){1'b0}}, alt_out.wide_timer_out} << PIN_TMR16)
                              | ({{(NPINS-1){1'b0}}, alt_out.buzzer_out} << PIN_BUZZ);
    wire [NPINS-1:0] out_nxt  = (alt_mask & alt_val) | (~alt_mask & lat_all);

    // edge detect on the second sync stage and a third history stage
    wire [2:0] irq_lvl  = pin_s2[PIN_IRQ_C:PIN_IRQ_A];
    wire [2:0] irq_prev = pin_s3[PIN_IRQ_C:PIN_IRQ_A];
    wire [2:0] irq_rise = irq_lvl & ~irq_prev;
    wire [2:0] irq_fall = ~irq_lvl & irq_prev;
    wire [2:0] irq_hit;
    genvar g;
    for (g = 0; g < 3; g++)
    begin : g_edge
        assign irq_hit[g] = (irq_rise[g] && edge_cfg_r[2*g])
                          || (irq_fall[g] && edge_cfg_r[2*g+1]);
    end
    // key return is active low: a falling edge is a key press
    wire [7:0] kr_hit = ~pin_s2[PIN_KEY0+:8] & pin_s3[PIN_KEY0+:8];

    // set wins over write-one-to-clear
    wire [2:0] irq_clr = wr_stat ? pwdata[2:0] : 3'h0;
    wire [7:0] kr_clr  = wr_stat ? pwdata[15:8] : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= RST_PINS;
            pin_s2 <= RST_PINS;
            pin_s3 <= RST_PINS;
        end
        else if (ce)
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_r    <= '0;
            dir_r      <= '0;
            pu_r       <= '0;
            alt_r      <= 6'h00;
            edge_cfg_r <= 6'h00;
        end
        else if (ce)
        begin
            if (wr_data)
                latch_r[idx] <= pwdata[7:0] & wmask;
            if (wr_dir)
                dir_r[idx] <= pwdata[7:0] & wmask;
            if (wr_pull)
                pu_r[idx] <= pwdata[7:0] & wmask;
            if (wr_alt)
                alt_r <= pwdata[5:0];
            if (wr_edge)
                edge_cfg_r <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_flag_r <= 3'h0;
            kr_flag_r  <= 8'h00;
            irq_req_r  <= 3'h0;
            kr_req_r   <= 1'b0;
        end
        else if (ce)
        begin
            irq_flag_r <= (irq_flag_r & ~irq_clr) | irq_hit;
            kr_flag_r  <= (kr_flag_r & ~kr_clr) | kr_hit;
            irq_req_r  <= irq_hit;
            kr_req_r   <= |kr_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_r  <= RST_PINS;
            pin_oe_n_r <= RST_OE_N;
            pull_en_r  <= RST_PINS;
            alt_in_r   <= '0;
        end
        else if (ce)
        begin
            pin_out_r  <= out_nxt;
            pin_oe_n_r <= ~dir_all;
            pull_en_r  <= pu_all & ~dir_all;
            alt_in_r   <= '{sync_serial_clk:      pin_s2[PIN_SCK],
                            async_serial_clk_in:  pin_s2[PIN_SCK],
                            sync_serial_din:      pin_s2[PIN_SIN],
                            async_receive_in:     pin_s2[PIN_SIN],
                            serial_chip_select_n: pin_s2[PIN_SSN],
                            ext_irq_in_a:         pin_s2[PIN_IRQ_A],
                            ext_irq_in_b:         pin_s2[PIN_IRQ_B],
                            ext_irq_in_c:         pin_s2[PIN_IRQ_C],
                            capture_edge_in:      pin_s2[PIN_IRQ_C],
                            small_timer_count_in: pin_s2[PIN_TMR8]};
        end
    end

    // no wait state: answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_r  <= setup;
            pslverr_r <= setup && !in_map;
            if (setup)
                prdata_r <= (in_map && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign pin_out        = pin_out_r;
    assign pin_oe_n       = pin_oe_n_r;
    assign pull_en        = pull_en_r;
    assign alt_in         = alt_in_r;
    assign pin_level      = pin_s2;
    assign ext_irq_req    = irq_req_r;
    assign key_return_req = kr_req_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_input_a: assert property ($rose(presetn) |-> &pin_oe_n && pull_en == 34'h0)
        else $error("pins not all input after reset");
    dir_follow_a: assert property (ce && wr_dir && idx == 3'h0 ##1 ce
        |=> pin_oe_n[7:0] == ~$past(pwdata[7:0], 2))
        else $error("direction write not reflected on port 0");
    pull_gate_a: assert property (ce |=> pull_en == $past(pu_all & ~dir_all))
        else $error("pull-up active on output pin or missing");
    irq_edge_a: assert property (ce && irq_rise[0] && edge_cfg_r[0]
        |=> irq_flag_r[0] && ext_irq_req[0])
        else $error("rising edge on interrupt a lost");
    irq_noedge_a: assert property (ce && irq_rise[1] && !irq_fall[1]
        && edge_cfg_r[3:2] == EDGE_FALL |=> !ext_irq_req[1])
        else $error("interrupt b fired on wrong edge");
    key_return_a: assert property (ce && kr_hit[0] |=> kr_flag_r[0] && key_return_req)
        else $error("key return press not flagged");
    serial_din_a: assert property (ce
        |=> alt_in.sync_serial_din == $past(pin_s2[PIN_SIN])
        && alt_in.serial_chip_select_n == $past(pin_s2[PIN_SSN]))
        else $error("serial input pins misrouted");
    capture_pin_a: assert property (ce
        |=> alt_in.capture_edge_in == $past(pin_s2[PIN_IRQ_C]))
        else $error("capture input misrouted");
    timer_out_a: assert property (ce && alt_r[ALT_TMR16]
        |=> pin_out[PIN_TMR16] == $past(alt_out.wide_timer_out))
        else $error("wide timer output not on its pin");
    sout_drive_a: assert property (ce && alt_r[ALT_SOUT] && !alt_r[ALT_TXD]
        |=> pin_out[PIN_SOUT] == $past(alt_out.sync_serial_dout))
        else $error("serial data output not driven by peripheral");
    bad_addr_a: assert property (ce && setup && paddr[15:8] != 8'h00 |=> pslverr && pready)
        else $error("out of map access not flagged");

    write_cov: cover property (wr_dir ##[1:20] wr_data);
    irq_cov:   cover property (irq_hit[2] && irq_clr[2]);
    key_cov:   cover property (|kr_hit);
    err_cov:   cover property (pslverr && pready);

endmodule : pps_port_pins

//--- verification/pps_board.sv
`timescale 1ns/1ps
module pps_board
    import pps_pkg::*;
(
    input  logic             pclk,
    input  logic [NPINS-1:0] pin_out,
    input  logic [NPINS-1:0] pin_oe_n,
    input  logic [NPINS-1:0] pull_en,
    input  logic [NPINS-1:0] drv_en,
    input  logic [NPINS-1:0] drv_val,
    output logic [NPINS-1:0] pin_in
);
    // a pad nobody drives or pulls wanders, so it toggles rather than holding
    logic flt_r = 1'b0;

    always @(posedge pclk)
        flt_r <= ~flt_r;

    always_comb
        for (int i = 0; i < NPINS; i++)
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] :
                        drv_en[i]    ? drv_val[i] :
                        pull_en[i]   ? 1'b1       : flt_r;
endmodule : pps_board

//--- verification/test_port_pins_with_alternate_functions.sv
`timescale 1ns/1ps
module test_port_pins_with_alternate_functions;
    import pps_pkg::*;

    logic             pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, key_return_req;
    logic [AW-1:0]    paddr;
    logic [31:0]      pwdata, prdata, rs;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe_n, pull_en, pin_level, drv_en, drv_val;
    logic [NPINS-1:0] e_dir, e_dat, e_pu;
    logic [2:0]       ext_irq_req;
    pps_alt_out_t     alt_out;
    pps_alt_in_t      alt_in;
    logic [32:0]      exp_q[$];
    int               miscompares, num_checks, cyc, irq_cnt, key_cnt;
    int               base[5] = '{0, 8, 16, 24, 26};
    int               apin[6] = '{16, 17, 17, 23, 24, 25};

    pps_port_pins DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .pull_en, .alt_out,
        .alt_in, .pin_level, .ext_irq_req, .key_return_req);

    pps_board board (.pclk, .pin_out, .pin_oe_n, .pull_en, .drv_en, .drv_val, .pin_in);

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    task automatic fail(input string m);
        miscompares++;
        $display("Error %0t: %s", $time, m);
    endtask : fail

    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1)
            fail(m);
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic w(input int n);
        repeat (n) @(negedge pclk);
    endtask : w

    // the answer is judged by the monitor, so every transfer notes its expectation
    task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read at the rising edge itself, before that edge updates it
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd

    always @(negedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            num_checks++;
            if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q.pop_front())
                fail("bus answer");
        end
        irq_cnt += $countones(ext_irq_req);
        key_cnt += int'(key_return_req);
        if (++cyc == 20000)
        begin
            fail("timeout");
            print_verdict();
        end
    end

    initial
    begin
        rs = 66;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        alt_out = '0;
        drv_en = '1;
        drv_val = '1;
        e_dir = '0;
        e_dat = '0;
        e_pu = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        w(1);
        chk(pin_oe_n === '1 && pull_en === '0 && pin_out === '0, "reset state");
        for (int p = 0; p < 5; p++)
        begin
            logic [7:0] m, d, v, u;
            m = (p == 3) ? 8'h03 : 8'hFF;
            d = 8'(rnd());
            v = 8'(rnd());
            u = 8'(rnd());
            wr(OFS_DATA + 16'(4 * p), {24'h0, d});
            wr(OFS_DIR + 16'(4 * p), {24'h0, v});
            wr(OFS_PULL + 16'(4 * p), {24'h0, u});
            rd(OFS_DIR + 16'(4 * p), {25'h0, v & m});
            for (int b = 0; b < 8; b++)
                if (m[b])
                begin
                    e_dir[base[p] + b] = v[b];
                    e_dat[base[p] + b] = d[b];
                    e_pu[base[p] + b] = u[b];
                end
        end
        w(3);
        chk(pin_oe_n === ~e_dir, "direction");
        chk((pin_out & e_dir) === (e_dat & e_dir), "output data");
        chk(pull_en === (e_pu & ~e_dir), "pull enable");
        wr(OFS_DIR + 16'h8, 32'hFF);
        wr(OFS_DIR + 16'hC, 32'h3);
        for (int k = 0; k < 6; k++)
        begin
            wr(OFS_ALT, 32'(1 << k));
            repeat (4)
            begin
                @(posedge pclk);
                alt_out <= 6'(rnd());
                w(3);
                chk(pin_out[apin[k]] === alt_out[5 - k], "alternate out");
            end
        end
        wr(OFS_ALT, 32'h0);
        wr(OFS_EDGE, 32'h0);
        for (int p = 0; p < 5; p++)
            wr(OFS_DIR + 16'(4 * p), 32'h0);
        repeat (4)
        begin
            @(posedge pclk);
            drv_val[23:16] <= 8'(rnd());
            w(5);
            chk(pin_level === pin_in && alt_in === {drv_val[PIN_SCK], drv_val[PIN_SCK],
                drv_val[PIN_SIN], drv_val[PIN_SIN], drv_val[PIN_SSN], drv_val[PIN_IRQ_A],
                drv_val[PIN_IRQ_B], drv_val[PIN_IRQ_C], drv_val[PIN_IRQ_C],
                drv_val[PIN_TMR8]}, "alternate in");
        end
        @(posedge pclk);
        drv_val[23:16] <= 8'hFF;
        for (int c = 0; c < 3; c++)
            for (int code = 1; code < 4; code++)
            begin
                wr(OFS_EDGE, 32'(code << (2 * c)));
                @(posedge pclk);
                drv_val[PIN_IRQ_A + c] <= 1'b0;
                w(8);
                wr(OFS_STATUS, 32'hFF07);
                irq_cnt = 0;
                @(posedge pclk);
                drv_val[PIN_IRQ_A + c] <= 1'b1;
                w(8);
                chk(irq_cnt == code % 2, "rising edge");
                @(posedge pclk);
                drv_val[PIN_IRQ_A + c] <= 1'b0;
                w(8);
                chk(irq_cnt == code % 2 + code / 2, "falling edge");
                rd(OFS_STATUS, 33'(1 << c));
                @(posedge pclk);
                drv_val[PIN_IRQ_A + c] <= 1'b1;
            end
        wr(OFS_EDGE, 32'h0);
        wr(OFS_STATUS, 32'hFF07);
        for (int k = 0; k < 8; k++)
        begin
            key_cnt = 0;
            @(posedge pclk);
            drv_val[PIN_KEY0 + k] <= 1'b0;
            w(8);
            chk(key_cnt == 1, "key return");
            rd(OFS_STATUS, 33'(32'h100 << k));
            wr(OFS_STATUS, 32'hFF00);
            @(posedge pclk);
            drv_val[PIN_KEY0 + k] <= 1'b1;
        end
        // a second reset with pulls and latches set must bring every pin back to input
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        w(1);
        chk(pin_oe_n === '1 && pull_en === '0 && pin_out === '0, "reset state");
        rd(16'h0100, {1'b1, 32'h0});
        rd(16'h0002, {1'b1, 32'h0});
        rd(OFS_END, {1'b1, 32'h0});
        apb(1'b1, 16'hFF20, 32'hFF, {1'b1, 32'h0});
        rd(OFS_DIR, 33'h0);
        w(4);
        print_verdict();
    end
endmodule : test_port_pins_with_alternate_functions
